// ---- verilog/fhbo_pkg.sv ----
// Constants for the host-side controller of a parallel word-wide flash bus.
// Assumes a 40 MHz system clock and a device with asynchronous pin timing.
package fhbo_pkg;

    // ----------------------------------------------------------------
    // Clock and pin timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 25;
    localparam int T_ACCESS_NS      = 120;
    localparam int T_WE_PULSE_NS    = 50;
    localparam int T_RESET_PULSE_NS = 500;
    localparam int T_RESET_READ_NS  = 50;
    localparam int T_READY_NS       = 20000;
    localparam int CNT_W            = 10;
    localparam int SYNC_DEPTH       = 3;

    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WP_CYC =
        CNT_W'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RP_CYC =
        CNT_W'((T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RH_CYC =
        CNT_W'((T_RESET_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] READY_CYC = CNT_W'(T_READY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RD_SAMPLE_CYC = ACC_CYC + CNT_W'(SYNC_DEPTH);

    // ----------------------------------------------------------------
    // User command codes
    // ----------------------------------------------------------------
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_FAST  = 2'h2;
    localparam logic [1:0] OP_RESET = 2'h3;

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_RD      = 4'h1,
        ST_WR_SET  = 4'h2,
        ST_WR_PUL  = 4'h3,
        ST_WR_HLD  = 4'h4,
        ST_RST_LOW = 4'h5,
        ST_RST_REC = 4'h6,
        ST_DONE    = 4'h7
    } fhbo_state_type;

endpackage : fhbo_pkg

// ---- verilog/fhbo_host.sv ----
// Host controller driving a parallel flash through its bus pins.
// Assumes the testbench resolves the data wire from FL_DQ_OE.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1 - Reads hold chip enable and output enable low together.
// RL2 - Write strobe stays high and data undriven during every read.
// RL3 - Device starts in array read after power-up or reset.
// RL4 - Device returns addressed word in array read until commanded otherwise.
// RL5 - Writes drive strobe and chip enable low, output enable high.
// RL6 - Fast program issues exactly two write cycles per word.
// RL7 - Device erases one sector, several, or the whole array.
// RL8 - High voltage on accel pin enters fast mode, lifts protection.
// RL9 - High program voltage applied only during fast programming.
// RL10 - Identification command returns codes on the low data byte.
// RL11 - Standby keeps device outputs high impedance.
// RL12 - Leaving standby needs full select access time.
// RL13 - Deselect during program or erase lets it finish.
// RL14 - Device sleeps after stable address for access time plus 30 ns.
// RL15 - In sleep, last data stays latched; new address gives new data.
// RL16 - Hard clear aborts work, tristates outputs, returns to array read.
// RL17 - Reset cutting a busy operation is reported so it is reissued; not flagged if taken in the first two ready cycles after a write.
// RL18 - Busy reset waits for ready, bounded by reset recovery time.
// RL19 - Idle reset completes within the shorter recovery time.
// RL20 - No read starts before reset-to-read delay after hard clear rises.
// RL21 - Device outputs disabled while output enable is high.
module fhbo_host
    import fhbo_pkg::*;
#(
    parameter int              ADDR_W   = 22,
    parameter int              DATA_W   = 16,
    parameter logic [15:0]     FAST_CMD = 16'h0000
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    // User command port
    input  wire logic              CMD_VALID,
    input  wire logic [1:0]        CMD_OP,
    input  wire logic              CMD_ACCEL,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [DATA_W-1:0] CMD_WDATA,
    output logic                   CMD_READY,
    // User response port
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_RDATA,
    output logic                   RSP_RESTART,
    // Flash pins
    output logic                   FL_CE_N,
    output logic                   FL_OE_N,
    output logic                   FL_WE_N,
    output logic                   FL_RESET_N,
    output logic                   FL_ACC_HV_EN,
    output logic [ADDR_W-1:0]      FL_ADDR,
    output logic [DATA_W-1:0]      FL_DQ_OUT,
    output logic                   FL_DQ_OE,
    input  wire logic [DATA_W-1:0] FL_DQ_IN,
    input  wire logic              FL_READY_BUSY_N
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_write(input fhbo_state_type st);
        is_write = (st == ST_WR_SET) || (st == ST_WR_PUL) || (st == ST_WR_HLD);
    endfunction : is_write

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fhbo_state_type    state_reg;
    fhbo_state_type    state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic [1:0]        op_reg;
    logic [1:0]        op_next;
    logic              accel_reg;
    logic              accel_next;
    logic              second_reg;
    logic              second_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic [DATA_W-1:0] dq_out_reg;
    logic [DATA_W-1:0] dq_out_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              restart_reg;
    logic              restart_next;
    logic              ready_reg;
    logic              rsp_reg;
    logic              ce_n_reg;
    logic              oe_n_reg;
    logic              we_n_reg;
    logic              rst_n_reg;
    logic              acc_reg;
    logic              dq_oe_reg;

    // ----------------------------------------------------------------
    // Pin input synchronisers
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] dq_s1_reg;
    logic [DATA_W-1:0] dq_s2_reg;
    logic [DATA_W-1:0] dq_s3_reg;
    logic              rb_s1_reg;
    logic              rb_s2_reg;
    logic              rb_s3_reg;
    logic              rb_filt_reg;
    wire               dq_stable = (dq_s2_reg == dq_s3_reg);

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dq_s1_reg   <= '0;
            dq_s2_reg   <= '0;
            dq_s3_reg   <= '0;
            rb_s1_reg   <= 1'b1;
            rb_s2_reg   <= 1'b1;
            rb_s3_reg   <= 1'b1;
            rb_filt_reg <= 1'b1;
        end else begin
            dq_s1_reg <= FL_DQ_IN;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
            rb_s1_reg <= FL_READY_BUSY_N;
            rb_s2_reg <= rb_s1_reg;
            rb_s3_reg <= rb_s2_reg;
            if (rb_s2_reg == rb_s3_reg) begin
                rb_filt_reg <= rb_s3_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        op_next      = op_reg;
        accel_next   = accel_reg;
        second_next  = second_reg;
        addr_next    = addr_reg;
        wdata_next   = wdata_reg;
        dq_out_next  = dq_out_reg;
        rdata_next   = rdata_reg;
        restart_next = restart_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (CMD_VALID && ready_reg) begin
                    op_next    = CMD_OP;
                    accel_next = CMD_ACCEL && (CMD_OP == OP_FAST);        // [RL9]
                    addr_next  = CMD_ADDR;
                    wdata_next = CMD_WDATA;
                    unique case (CMD_OP)
                        OP_READ: begin
                            state_next = ST_RD;
                        end
                        OP_WRITE: begin
                            state_next  = ST_WR_SET;
                            second_next = 1'b0;
                            dq_out_next = CMD_WDATA;
                        end
                        OP_FAST: begin
                            state_next  = ST_WR_SET;
                            second_next = 1'b1;                           // [RL6]
                            dq_out_next = DATA_W'(FAST_CMD);
                        end
                        OP_RESET: begin
                            state_next   = ST_RST_LOW;
                            restart_next = !rb_filt_reg;                  // [RL17]
                        end
                    endcase
                end
            end
            ST_RD: begin
                if (cnt_reg >= RD_SAMPLE_CYC && dq_stable) begin          // [RL1]
                    rdata_next = dq_s3_reg;
                    state_next = ST_DONE;
                end
            end
            ST_WR_SET: begin
                state_next = ST_WR_PUL;
            end
            ST_WR_PUL: begin
                if (cnt_reg >= WP_CYC - CNT_W'(1)) begin
                    state_next = ST_WR_HLD;
                end
            end
            ST_WR_HLD: begin
                if (second_reg) begin
                    second_next = 1'b0;                                   // [RL6]
                    dq_out_next = wdata_reg;
                    state_next  = ST_WR_SET;
                end else begin
                    state_next = ST_DONE;
                end
            end
            ST_RST_LOW: begin
                if (cnt_reg >= RP_CYC - CNT_W'(1)) begin
                    state_next = ST_RST_REC;
                end
            end
            ST_RST_REC: begin
                if ((cnt_reg >= RH_CYC && rb_filt_reg) || cnt_reg >= READY_CYC) begin // [RL20]
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign cnt_next = (state_next != state_reg) ? '0 : cnt_reg + CNT_W'(1);

    // ----------------------------------------------------------------
    // Pin decode from the next state
    // ----------------------------------------------------------------
    wire ce_n_next  = !(state_next == ST_RD || is_write(state_next));   // [RL1] [RL5]
    wire oe_n_next  = !(state_next == ST_RD);                            // [RL2] [RL5]
    wire we_n_next  = !(state_next == ST_WR_PUL);                        // [RL2] [RL5]
    wire rst_n_next = !(state_next == ST_RST_LOW);
    wire acc_next   = accel_next && is_write(state_next);                // [RL9]
    wire oe_dq_next = is_write(state_next);                              // [RL2]

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= '0;
            op_reg      <= OP_READ;
            accel_reg   <= 1'b0;
            second_reg  <= 1'b0;
            addr_reg    <= '0;
            wdata_reg   <= '0;
            dq_out_reg  <= '0;
            rdata_reg   <= '0;
            restart_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            op_reg      <= op_next;
            accel_reg   <= accel_next;
            second_reg  <= second_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            dq_out_reg  <= dq_out_next;
            rdata_reg   <= rdata_next;
            restart_reg <= restart_next;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ready_reg <= 1'b0;
            rsp_reg   <= 1'b0;
            ce_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            rst_n_reg <= 1'b1;
            acc_reg   <= 1'b0;
            dq_oe_reg <= 1'b0;
        end else begin
            ready_reg <= (state_next == ST_IDLE);
            rsp_reg   <= (state_next == ST_DONE);
            ce_n_reg  <= ce_n_next;
            oe_n_reg  <= oe_n_next;
            we_n_reg  <= we_n_next;
            rst_n_reg <= rst_n_next;
            acc_reg   <= acc_next;
            dq_oe_reg <= oe_dq_next;
        end
    end

    assign CMD_READY    = ready_reg;
    assign RSP_VALID    = rsp_reg;
    assign RSP_RDATA    = rdata_reg;
    assign RSP_RESTART  = restart_reg;
    assign FL_CE_N      = ce_n_reg;
    assign FL_OE_N      = oe_n_reg;
    assign FL_WE_N      = we_n_reg;
    assign FL_RESET_N   = rst_n_reg;
    assign FL_ACC_HV_EN = acc_reg;
    assign FL_ADDR      = addr_reg;
    assign FL_DQ_OUT    = dq_out_reg;
    assign FL_DQ_OE     = dq_oe_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    localparam int RDY_BOUND = 802;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence first_strobe_s;
        $fell(FL_WE_N) && second_reg;
    endsequence

    sequence second_strobe_s;
        ##[1:20] ($fell(FL_WE_N) && !second_reg) ##1 !FL_WE_N ##1 FL_WE_N [*3];
    endsequence

    read_ctrl_a: assert property (state_reg == ST_RD |-> !FL_CE_N && !FL_OE_N) // [RL1]
        else $error("Read without chip and output enable low");

    read_quiet_a: assert property (!FL_OE_N |-> FL_WE_N && !FL_DQ_OE)           // [RL2]
        else $error("Strobe or data driven during read");

    write_ctrl_a: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE) // [RL5]
        else $error("Write strobe with wrong control levels");

    fast_two_a: assert property (first_strobe_s |-> second_strobe_s)            // [RL6]
        else $error("Fast program did not give exactly two strobes");

    accel_only_a: assert property (FL_ACC_HV_EN |-> op_reg == OP_FAST && FL_OE_N) // [RL9]
        else $error("High program voltage outside fast program");

    restart_flag_a: assert property (                                            // [RL17]
        state_reg == ST_IDLE && CMD_READY && CMD_VALID && CMD_OP == OP_RESET
        |=> RSP_RESTART == !$past(rb_filt_reg))
        else $error("Restart flag does not follow busy state at reset");

    reset_hold_a: assert property ($rose(FL_RESET_N) |-> FL_OE_N [*2])           // [RL20]
        else $error("Read started too soon after hard clear");

    ready_wait_a: assert property (                                              // [RL18]
        $rose(FL_RESET_N) |-> ##[1:RDY_BOUND] RSP_VALID)
        else $error("Reset recovery exceeded its bound");

endmodule : fhbo_host

`default_nettype wire

// ---- testbench/fhbo_flash_model.sv ----
// Behavioural model of the word-wide flash as seen at its pins.
// Assumes the bench resolves the shared data wire and returns it on dq_in.
`timescale 1ns/1ps
`default_nettype none
module fhbo_flash_model #(
    parameter logic [15:0] FAST_CMD  = 16'h0000,
    parameter int          ACCESS_NS = 120,
    parameter int          RH_NS     = 50,
    parameter int          PROG_NS   = 2000,
    parameter int          RECOV_NS  = 1500,
    parameter logic [15:0] IDENT_CMD     = 16'h00a1,
    parameter logic [15:0] ERASE_CMD     = 16'h00b2,
    parameter logic [15:0] ERASE_ALL_CMD = 16'h00c3,
    parameter logic [7:0]  IDENT_CODE    = 8'h5c // Arbitrary value
) (
    // Bus pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rst_n,
    input  wire logic        acc_hv,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] dq_in,
    // Test control
    input  wire logic        slow,
    // Device outputs
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             ready_busy_n
);
    logic [15:0] mem [0:255];
    logic        armed;
    logic        commit;
    logic        ident;
    logic        valid;
    logic [7:0]  p_idx;
    logic [15:0] p_dat;
    realtime     chg_t;
    realtime     rise_t;
    realtime     done_t;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
        armed = 1'b0;
        commit = 1'b0;
        ident = 1'b0;
        valid = 1'b0;
        ready_busy_n = 1'b1;
        chg_t = 0;
        rise_t = 0;
        done_t = 0;
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign dq_oe = !ce_n && !oe_n && rst_n;
    wire [15:0] arr_word = ident ? {8'h00, IDENT_CODE} : mem[addr[7:0]];
    assign dq_out = valid ? arr_word : ~arr_word;

    always @(addr, ce_n, oe_n, rst_n) chg_t = $realtime;
    always @(posedge rst_n) rise_t = $realtime;

    always #1 begin
        valid = ($realtime - chg_t >= ACCESS_NS) && ($realtime - rise_t >= RH_NS);
        if (!ready_busy_n && $realtime >= done_t) begin
            if (commit) mem[p_idx] = mem[p_idx] & p_dat;
            commit = 1'b0;
            ready_busy_n = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Write path and hard clear
    // ----------------------------------------------------------------
    always @(posedge we_n) begin
        if (!ce_n && oe_n && rst_n && ready_busy_n) begin
            if (armed) begin
                p_idx = addr[7:0];
                p_dat = dq_in;
                commit = 1'b1;
                armed = 1'b0;
                ready_busy_n = 1'b0;
                done_t = $realtime + (acc_hv ? PROG_NS / 4 : (slow ? 2 * PROG_NS : PROG_NS));
            end else if (dq_in === IDENT_CMD) begin
                ident = 1'b1;
            end else if (dq_in === ERASE_CMD || dq_in === ERASE_ALL_CMD) begin
                for (int i = 0; i < 256; i++)
                    if (dq_in === ERASE_ALL_CMD || i[7:4] == addr[7:4]) mem[i] = 16'hffff;
                ready_busy_n = 1'b0;
                done_t = $realtime + PROG_NS;
            end else armed = (dq_in === FAST_CMD);
        end
    end

    always @(negedge rst_n) begin
        armed = 1'b0;
        ident = 1'b0;
        if (!ready_busy_n) begin
            commit = 1'b0;
            done_t = $realtime + RECOV_NS;
        end
    end
endmodule : fhbo_flash_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the flash bus host controller.
// Assumes the flash model stands on the pins and FAST_CMD keeps its default.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb
    import fhbo_pkg::*;
;
    logic        clk, sys_rst, cmd_valid, cmd_accel, slow, acc_seen;
    logic [1:0]  cmd_op;
    logic [21:0] cmd_addr, fl_addr, a;
    logic [15:0] cmd_wdata, rsp_rdata, dq_out, dev_dout, bus, last_drv, d;
    logic [15:0] shadow [0:255];
    logic        cmd_ready, rsp_valid, rsp_restart, ce_n, oe_n, we_n, rst_n;
    logic        acc_hv, dq_oe, dev_oe, rdy_n;
    int          num_errors, checked, cycles, we_cnt, rst_cnt, seed;
    localparam logic [15:0] IDENT_CMD     = 16'h00a1;
    localparam logic [15:0] ERASE_CMD     = 16'h00b2;
    localparam logic [15:0] ERASE_ALL_CMD = 16'h00c3;
    localparam logic [7:0]  IDENT_CODE    = 8'h5c; // Arbitrary value

    fhbo_host dut_u (.CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ACCEL(cmd_accel), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
        .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RSP_RESTART(rsp_restart), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
        .FL_RESET_N(rst_n), .FL_ACC_HV_EN(acc_hv), .FL_ADDR(fl_addr), .FL_DQ_OUT(dq_out),
        .FL_DQ_OE(dq_oe), .FL_DQ_IN(bus), .FL_READY_BUSY_N(rdy_n));
    fhbo_flash_model #(.IDENT_CMD(IDENT_CMD), .ERASE_CMD(ERASE_CMD),
        .ERASE_ALL_CMD(ERASE_ALL_CMD), .IDENT_CODE(IDENT_CODE))
        flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(rst_n),
        .acc_hv(acc_hv), .addr(fl_addr), .dq_in(bus), .slow(slow), .dq_out(dev_dout),
        .dq_oe(dev_oe), .ready_busy_n(rdy_n));

    // ----------------------------------------------------------------
    // Clock, data wire and pin monitor
    // ----------------------------------------------------------------
    always #12.5 clk = ~clk;
    always @* if (dq_oe) last_drv = dq_out; else if (dev_oe) last_drv = dev_dout;
    assign bus = dq_oe ? dq_out : (dev_oe ? dev_dout : ~last_drv);
    always @(negedge we_n) we_cnt++;

    always @(negedge clk) begin
        if (oe_n === 1'b0) `CHK("read strobes", 3'b010, {ce_n, we_n, dq_oe})
        if (we_n === 1'b0) `CHK("write strobes", 2'b01, {ce_n, oe_n})
        if (acc_hv === 1'b1) `CHK("accel op", OP_FAST, cmd_op)
        if (acc_hv === 1'b1) acc_seen = 1'b1;
        if (rst_n === 1'b0) rst_cnt++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic do_cmd(input logic [1:0] op, input logic acc, input logic [21:0] ad,
                          input logic [15:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        `CHK("command ready", 1'b1, cmd_ready)
        cmd_op = op;
        cmd_accel = acc;
        cmd_addr = ad;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        we_cnt = 0;
        rst_cnt = 0;
        acc_seen = 1'b0;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        `CHK("response", 1'b1, rsp_valid)
    endtask : do_cmd

    task automatic rd_chk(input logic [21:0] ad);
        do_cmd(OP_READ, 1'b0, ad, 16'h0000);
        `CHK("read data", shadow[ad[7:0]], rsp_rdata)
    endtask : rd_chk

    task automatic prog(input logic [21:0] ad, input logic [15:0] wd, input logic acc);
        do_cmd(OP_FAST, acc, ad, wd);
        `CHK("write pulses", 2, we_cnt)
        `CHK("accel pin", acc, acc_seen)
    endtask : prog

    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy_n !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        `CHK("ready after busy", 1'b1, rdy_n)
        repeat (4) @(negedge clk);
    endtask : wait_ready

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    function automatic logic [15:0] init_word(input int i);
        init_word = {i[7:0], ~i[7:0]};
    endfunction : init_word

    function automatic logic [15:0] prog_word(input logic [15:0] old, input logic [15:0] wd);
        prog_word = old & wd;
    endfunction : prog_word

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = OP_READ;
        cmd_accel = 1'b0;
        cmd_addr = 22'h000000;
        cmd_wdata = 16'h0000;
        slow = 1'b0;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        seed = 93;
        for (int i = 0; i < 256; i++) shadow[i] = init_word(i);
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 6; i++) rd_chk(i < 2 ? {22{i[0]}} : 22'($random(seed)));
        do_cmd(OP_WRITE, 1'b1, 22'h000011, 16'h1234);
        `CHK("single write pulses", 1, we_cnt)
        `CHK("accel on plain write", 1'b0, acc_seen)
        for (int i = 0; i < 6; i++) begin
            a = 22'($random(seed));
            d = 16'($random(seed));
            slow = i[1];
            prog(a, d, i[0]);
            shadow[a[7:0]] = prog_word(shadow[a[7:0]], d);
            wait_ready();
            rd_chk(a);
            rd_chk(a ^ 22'h000001);
        end
        slow = 1'b0;
        do_cmd(OP_WRITE, 1'b0, a, ERASE_CMD);
        wait_ready();
        for (int i = 0; i < 16; i++) shadow[{a[7:4], i[3:0]}] = 16'hffff;
        rd_chk(a);
        rd_chk({a[21:4], 4'hf});
        do_cmd(OP_WRITE, 1'b0, 22'h000000, IDENT_CMD);
        do_cmd(OP_READ, 1'b0, 22'h000000, 16'h0000);
        `CHK("ident code", IDENT_CODE, rsp_rdata[7:0])
        do_cmd(OP_RESET, 1'b0, 22'h000000, 16'h0000);
        `CHK("restart after idle reset", 1'b0, rsp_restart)
        `CHK("reset pulse", int'(RP_CYC), rst_cnt)
        rd_chk(a);
        a = 22'h2a5a33;
        prog(a, 16'h0000, 1'b0);
        repeat (4) @(negedge clk);
        do_cmd(OP_RESET, 1'b0, 22'h000000, 16'h0000);
        `CHK("restart after busy reset", 1'b1, rsp_restart)
        `CHK("ready at reset end", 1'b1, rdy_n)
        rd_chk(a);
        prog(a, 16'h0000, 1'b1);
        shadow[a[7:0]] = 16'h0000;
        wait_ready();
        rd_chk(a);
        do_cmd(OP_WRITE, 1'b0, 22'h000000, ERASE_ALL_CMD);
        wait_ready();
        for (int i = 0; i < 256; i++) shadow[i] = 16'hffff;
        rd_chk(a);
        rd_chk(22'($random(seed)));
        finish_test();
    end
endmodule : tb
`default_nettype wire
